// File: opebd_addr_decode.sv
`timescale 1ns/1ps
`default_nettype none

module opebd_addr_decode (
  input wire logic [15:0] enables,
  input wire logic globalEn,
  input wire logic strapHigh,
  input wire opebd_pkg::opebd_req_t req,
  output opebd_pkg::opebd_dec_t dec
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic inRange(input logic [23:0] a, input logic [23:0] lo,
                                   input logic [23:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // window hits
  wire logic [23:0] a = req.addr;
  wire logic hitSsc = inRange(a, opebd_pkg::SSC_LO, opebd_pkg::SSC_HI);
  wire logic hitAsc = inRange(a, opebd_pkg::ASC_LO, opebd_pkg::ASC_HI);
  wire logic hitTwi = inRange(a, opebd_pkg::TWI_LO, opebd_pkg::TWI_HI);
  wire logic hitMisc = inRange(a, opebd_pkg::MISC_LO, opebd_pkg::MISC_HI);
  wire logic hitPwm = inRange(a, opebd_pkg::PWM_LO, opebd_pkg::PWM_HI);
  wire logic hitRtc = inRange(a, opebd_pkg::RTC_LO, opebd_pkg::RTC_HI);
  wire logic hitCan = inRange(a, opebd_pkg::CAN_LO, opebd_pkg::CAN_HI);
  wire logic hitPer = inRange(a, opebd_pkg::PER_LO, opebd_pkg::PER_HI);
  wire logic hitSram = inRange(a, opebd_pkg::SRAM_LO, opebd_pkg::SRAM_HI);
  wire logic hitLram = inRange(a, opebd_pkg::LRAM_LO, opebd_pkg::LRAM_HI);
  wire logic hitFlash = inRange(a, opebd_pkg::FLASH_LO, opebd_pkg::FLASH_HI);
  wire logic hitSeg8 = (a[23:16] == opebd_pkg::SEG8);
  // can selects leave the pwm and rtc windows to their own modules
  wire logic hitCanOwn = hitCan & ~hitPwm & ~hitRtc;

  // live enables only count with the on-chip bus switched on
  wire logic [15:0] en = globalEn ? enables : 16'h0000;
  wire logic anySmall = |(en & opebd_pkg::SMALL_PERIPH_MASK);
  wire logic canAny = en[opebd_pkg::BIT_CAN1] | en[opebd_pkg::BIT_CAN2];

  // per-module internal selects
  wire logic [10:0] sel;
  assign sel[opebd_pkg::BIT_CAN1] = hitCanOwn & en[opebd_pkg::BIT_CAN1];
  assign sel[opebd_pkg::BIT_CAN2] = hitCanOwn & en[opebd_pkg::BIT_CAN2];
  assign sel[opebd_pkg::BIT_SRAM] = hitSram & en[opebd_pkg::BIT_SRAM];
  assign sel[opebd_pkg::BIT_LRAM] = hitLram & en[opebd_pkg::BIT_LRAM];
  assign sel[opebd_pkg::BIT_RTC] = hitRtc & en[opebd_pkg::BIT_RTC];
  assign sel[opebd_pkg::BIT_FLASH] = hitFlash & en[opebd_pkg::BIT_FLASH];
  assign sel[opebd_pkg::BIT_PWM] = hitPwm & en[opebd_pkg::BIT_PWM];
  assign sel[opebd_pkg::BIT_ASYNC] = hitAsc & en[opebd_pkg::BIT_ASYNC];
  assign sel[opebd_pkg::BIT_SYNC] = hitSsc & en[opebd_pkg::BIT_SYNC];
  assign sel[opebd_pkg::BIT_TWI] = hitTwi & en[opebd_pkg::BIT_TWI];
  assign sel[opebd_pkg::BIT_MISC] = hitMisc & en[opebd_pkg::BIT_MISC];

  // memory windows shared between large ram and flash
  wire logic bigMemEn = en[opebd_pkg::BIT_LRAM] | en[opebd_pkg::BIT_FLASH];
  wire logic bigHit = hitLram | hitFlash;

  // segment 8 mapping from the strap
  wire logic seg8Int = hitSeg8 & strapHigh;
  wire logic seg8Res = hitSeg8 & ~strapHigh & globalEn & bigMemEn;
  wire logic seg8Ext = hitSeg8 & ~strapHigh & ~seg8Res;

  // final route: internal module, reserved hole or external interface
  wire logic anySel = |sel;
  wire logic perExt = hitPer & ~anySmall & ~canAny;
  wire logic bigExt = bigHit & ~bigMemEn;
  wire logic sramExt = hitSram & ~en[opebd_pkg::BIT_SRAM];
  wire logic isExt = perExt | bigExt | sramExt | seg8Ext |
                     ~(hitPer | bigHit | hitSram | hitSeg8);

  wire logic [10:0] selOut = req.valid ? sel : 11'h000;
  wire logic iflashOut = req.valid & seg8Int;
  // a blocked hit that no external rule claims falls to the reserved code
  wire logic [3:0] routeSel = ~req.valid ? opebd_pkg::ROUTE_NONE :
                              (anySel | seg8Int) ? opebd_pkg::ROUTE_INTERNAL :
                              seg8Res ? opebd_pkg::ROUTE_RESERVED :
                              isExt ? opebd_pkg::ROUTE_EXTERNAL :
                              opebd_pkg::ROUTE_RESERVED;
  assign dec = {routeSel, selOut, iflashOut};

endmodule

`default_nettype wire

// File: opebd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// cpu access source
// ------------------------------------------------------------
module opebd_cpu_model (
  input wire logic clk,
  output opebd_pkg::opebd_req_t req
);
  initial req = '0;

  // one-cycle access; released address inverted so no stale match
  task automatic issue(input logic [23:0] a);
    @(posedge clk);
    req <= '{valid: 1'b1, addr: a};
    @(posedge clk);
    req <= '{valid: 1'b0, addr: ~a};
  endtask
endmodule

`default_nettype wire

// File: opebd_enable_decode.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - first CAN bit clear blocks CAN1; shared range external only if all clear
// - second CAN bit clear blocks CAN2; shared range external only if all clear
// - small ram bit clear sends its 2K range external; set makes it internal once global enable is on
// - large ram bit clear disables it; external only if flash bit clear too
// - rtc bit clear blocks rtc; external only when all small enables clear
// - pwm bit clear blocks pwm; external only when all small enables clear
// - flash bit clear blocks flash; external only if large ram bit clear
// - async serial bit clear blocks it; external only when all small clear
// - sync serial bit clear blocks it; external only when all small clear
// - two-wire bit clear blocks it; external only when all small clear
// - misc bit clear blocks extras; external only when all small clear
// - all small enables clear sends the whole peripheral window external
// - pins of a disabled peripheral are released for general I/O
// - reset leaves CAN1 and small ram enabled, value 005h
// - global bus enable set locks the enable register
// - emulation mode treats every enable bit as set
// - segment 8 maps by strap, global enable and the big memory bits
module opebd_enable_decode (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic externalAccessStrap,
  input wire logic cpuValid,
  input wire logic [23:0] cpuAddr,
  output logic [3:0] routeOut,
  output logic [10:0] moduleSelect,
  output logic iflashSelect,
  output logic [10:0] pinRelease
);

  // ------------------------------------------------------------
  // bus address phase capture
  // ------------------------------------------------------------
  logic wrPend_reg;
  logic [15:0] wrAddr_reg;
  logic [31:0] hrdata_reg;
  wire logic accept = hsel & hready & htrans[1];
  wire logic [15:0] curAddr = haddr[15:0];

  // address decode for the data-phase write
  wire logic wrEnCtrl = wrPend_reg & (wrAddr_reg == opebd_pkg::ENABLE_CTRL_OFFSET);
  wire logic wrSysCtrl = wrPend_reg & (wrAddr_reg == opebd_pkg::SYS_CTRL_OFFSET);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] peripheral_enable_control_reg;
  logic [15:0] peripheral_enable_control_next;
  logic onchipGlobal_reg;
  logic emuMode_reg;
  logic strap_reg;
  logic strapTaken_reg;

  // locked once global enable is set; upper bits kept zero
  wire logic enLocked = onchipGlobal_reg;
  assign peripheral_enable_control_next =
    (wrEnCtrl & ~enLocked) ? (hwdata[15:0] & opebd_pkg::ENABLE_CTRL_MASK)
                           : peripheral_enable_control_reg;

  // enable register with reset default
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peripheral_enable_control_reg <= opebd_pkg::ENABLE_CTRL_RESET;
    end else begin
      peripheral_enable_control_reg <= peripheral_enable_control_next;
    end
  end

  // system control: global enable sticks until reset, emulation flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      onchipGlobal_reg <= 1'b0;
      emuMode_reg <= 1'b0;
    end else if (wrSysCtrl) begin
      onchipGlobal_reg <= onchipGlobal_reg | hwdata[opebd_pkg::SYS_BIT_GLOBAL];
      emuMode_reg <= hwdata[opebd_pkg::SYS_BIT_EMU];
    end
  end

  // strap caught on the first clock after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_reg <= 1'b0;
      strapTaken_reg <= 1'b0;
    end else if (!strapTaken_reg) begin
      strap_reg <= externalAccessStrap;
      strapTaken_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // read mux and bus handshake
  // ------------------------------------------------------------
  wire logic [31:0] sysWord = {30'h0, emuMode_reg, onchipGlobal_reg};
  wire logic [31:0] statWord = {29'h0, strapTaken_reg, strap_reg, enLocked};
  wire logic [31:0] rdMux;
  assign rdMux = (curAddr == opebd_pkg::ENABLE_CTRL_OFFSET) ?
                   {16'h0000, peripheral_enable_control_reg} :
                 (curAddr == opebd_pkg::SYS_CTRL_OFFSET) ? sysWord :
                 (curAddr == opebd_pkg::STATUS_OFFSET) ? statWord : 32'h0000_0000;

  // zero-wait slave: capture write, load read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 16'h0000;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= accept & hwrite;
      wrAddr_reg <= curAddr;
      hrdata_reg <= (accept & ~hwrite) ? rdMux : hrdata_reg;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------------------
  // routing
  // ------------------------------------------------------------
  wire logic [15:0] effEnables =
    emuMode_reg ? opebd_pkg::ENABLE_CTRL_MASK : peripheral_enable_control_reg;
  wire logic effGlobal = onchipGlobal_reg | emuMode_reg;
  wire opebd_pkg::opebd_req_t req = {cpuValid, cpuAddr};
  opebd_pkg::opebd_dec_t dec;

  opebd_addr_decode u_decode (
    .enables(effEnables),
    .globalEn(effGlobal),
    .strapHigh(strap_reg),
    .req(req),
    .dec(dec)
  );

  // registered route outputs and pin release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      routeOut <= opebd_pkg::ROUTE_NONE;
      moduleSelect <= 11'h000;
      iflashSelect <= 1'b0;
      pinRelease <= 11'h7FA;
    end else begin
      routeOut <= dec.route;
      moduleSelect <= dec.select;
      iflashSelect <= dec.iflash;
      pinRelease <= ~effEnables[10:0];
    end
  end

endmodule

`default_nettype wire

// File: opebd_enable_decode_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// routing checker
// ------------------------------------------------------------
module opebd_enable_decode_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cpuValid,
  input wire logic [23:0] cpuAddr,
  input wire logic [3:0] routeOut,
  input wire logic [10:0] moduleSelect,
  input wire logic iflashSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // request shapes
  sequence seg8Req;
    cpuValid && cpuAddr[23:16] == opebd_pkg::SEG8;
  endsequence
  sequence sramReq;
    cpuValid && cpuAddr >= opebd_pkg::SRAM_LO && cpuAddr <= opebd_pkg::SRAM_HI;
  endsequence
  sequence farReq;
    cpuValid && cpuAddr[23:20] != 4'h0;
  endsequence

  // route and bus answer shape
  a_route_onehot: assert property ($onehot(routeOut)) else $error("route not one-hot");
  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus answer bad");
  a_idle_none: assert property (!cpuValid |=> routeOut == 4'h1 && moduleSelect == 11'h000)
    else $error("idle cycle routed");
  a_far_external: assert property (farReq |=> routeOut == 4'h4 && moduleSelect == 11'h000)
    else $error("outside address not external");
  a_sram_routed: assert property (sramReq |=> (routeOut == 4'h4 && moduleSelect == 11'h000)
    || (routeOut == 4'h2 && moduleSelect == 11'h004)) else $error("small ram route wrong");
  a_iflash_cause: assert property (iflashSelect |-> $past(cpuValid && cpuAddr[23:16] == 8'h08))
    else $error("iflash without segment 8");
  a_reserved_cause: assert property (routeOut == 4'h8 |-> $past(cpuValid &&
    ((cpuAddr >= 24'h00E000 && cpuAddr <= 24'h00EFFF) || cpuAddr[23:19] == 5'b00001)))
    else $error("reserved outside mapped windows");
  a_seg8_served: assert property (seg8Req |=> routeOut != 4'h1)
    else $error("segment 8 blocked");
  a_select_internal: assert property (moduleSelect != 11'h000
    |-> routeOut == 4'h2 && $onehot(moduleSelect)) else $error("select without internal");
endmodule

bind opebd_enable_decode opebd_enable_decode_sva chk_u (.clk(clk), .rstn(rstn),
  .hreadyout(hreadyout), .hresp(hresp), .cpuValid(cpuValid), .cpuAddr(cpuAddr),
  .routeOut(routeOut), .moduleSelect(moduleSelect), .iflashSelect(iflashSelect));

`default_nettype wire

// File: opebd_pkg.sv
package opebd_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] ENABLE_CTRL_OFFSET = 16'hF024;
  localparam logic [15:0] SYS_CTRL_OFFSET = 16'hF028;
  localparam logic [15:0] STATUS_OFFSET = 16'hF02C;
  localparam logic [15:0] ENABLE_CTRL_RESET = 16'h0005;
  localparam logic [15:0] ENABLE_CTRL_MASK = 16'h07FF;

  // ------------------------------------------------------------
  // enable bit positions
  // ------------------------------------------------------------
  localparam int BIT_CAN1 = 0;
  localparam int BIT_CAN2 = 1;
  localparam int BIT_SRAM = 2;
  localparam int BIT_LRAM = 3;
  localparam int BIT_RTC = 4;
  localparam int BIT_FLASH = 5;
  localparam int BIT_PWM = 6;
  localparam int BIT_ASYNC = 7;
  localparam int BIT_SYNC = 8;
  localparam int BIT_TWI = 9;
  localparam int BIT_MISC = 10;
  localparam logic [15:0] SMALL_PERIPH_MASK = 16'h07D3;

  // system control bit positions
  localparam int SYS_BIT_GLOBAL = 0;
  localparam int SYS_BIT_EMU = 1;

  // ------------------------------------------------------------
  // address windows (24-bit cpu address)
  // ------------------------------------------------------------
  localparam logic [23:0] SSC_LO = 24'h00E800;
  localparam logic [23:0] SSC_HI = 24'h00E8FF;
  localparam logic [23:0] ASC_LO = 24'h00E900;
  localparam logic [23:0] ASC_HI = 24'h00E9FF;
  localparam logic [23:0] TWI_LO = 24'h00EA00;
  localparam logic [23:0] TWI_HI = 24'h00EAFF;
  localparam logic [23:0] MISC_LO = 24'h00EB00;
  localparam logic [23:0] MISC_HI = 24'h00EBFF;
  localparam logic [23:0] PWM_LO = 24'h00EC00;
  localparam logic [23:0] PWM_HI = 24'h00ECFF;
  localparam logic [23:0] RTC_LO = 24'h00ED00;
  localparam logic [23:0] RTC_HI = 24'h00EDFF;
  localparam logic [23:0] CAN_LO = 24'h00EC00;
  localparam logic [23:0] CAN_HI = 24'h00EFFF;
  localparam logic [23:0] PER_LO = 24'h00E800;
  localparam logic [23:0] PER_HI = 24'h00EFFF;
  localparam logic [23:0] SRAM_LO = 24'h00E000;
  localparam logic [23:0] SRAM_HI = 24'h00E7FF;
  localparam logic [23:0] LRAM_LO = 24'h0F0000;
  localparam logic [23:0] LRAM_HI = 24'h0FFFFF;
  localparam logic [23:0] FLASH_LO = 24'h090000;
  localparam logic [23:0] FLASH_HI = 24'h0EFFFF;
  localparam logic [7:0] SEG8 = 8'h08;

  // ------------------------------------------------------------
  // route targets
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ROUTE_NONE = 4'h1,
    ROUTE_INTERNAL = 4'h2,
    ROUTE_EXTERNAL = 4'h4,
    ROUTE_RESERVED = 4'h8
  } opebd_route_t;

  // cpu access request
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
  } opebd_req_t;

  // routing answer
  typedef struct packed {
    opebd_route_t route;
    logic [10:0] select;
    logic iflash;
  } opebd_dec_t;

endpackage

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module tb_top;
  logic clk;
  logic rstn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic strap;
  opebd_pkg::opebd_req_t cpuReq;
  logic [3:0] routeOut;
  logic [10:0] moduleSelect;
  logic iflashSelect;
  logic [10:0] pinRelease;
  int fail_count = 0;
  int checks_done = 0;
  // routes with enables 121h locked in, strap low
  logic [23:0] tAddr [9] = '{24'h00EE00, 24'h00E800, 24'h00E9FF, 24'h00EA00, 24'h00EB00,
    24'h00E000, 24'h0F0000, 24'h0EFFFF, 24'h080000};
  logic [3:0] tRoute [9] = '{4'h2, 4'h2, 4'h8, 4'h8, 4'h8, 4'h4, 4'h8, 4'h2, 4'h8};
  logic [10:0] tSel [9] = '{11'h001, 11'h100, 11'h000, 11'h000, 11'h000, 11'h000, 11'h000,
    11'h020, 11'h000};

  opebd_enable_decode dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .externalAccessStrap(strap),
    .cpuValid(cpuReq.valid), .cpuAddr(cpuReq.addr), .routeOut(routeOut),
    .moduleSelect(moduleSelect), .iflashSelect(iflashSelect), .pinRelease(pinRelease));
  opebd_cpu_model cpu_u (.clk(clk), .req(cpuReq));

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait for ready sampled high at a rising edge
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        wrap_up();
      end
      @(posedge clk);
    end
  endtask

  // one single-word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    chk("read", q, e);
  endtask

  // one cpu access, route checked once the registered answer lands
  task automatic rt(input logic [23:0] a, input logic [3:0] r, input logic [10:0] s,
    input logic f);
    cpu_u.issue(a);
    #1;
    chk("route", {28'h0, routeOut}, {28'h0, r});
    chk("select", {21'h0, moduleSelect}, {21'h0, s});
    chk("iflash", {31'h0, iflashSelect}, {31'h0, f});
    @(posedge clk);
  endtask

  task automatic doReset(input logic s);
    rstn <= 1'b0;
    strap <= s;
    hsel <= 1'b0;
    haddr <= 32'h00000000;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= 3'b010;
    hwdata <= 32'h00000000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask

  // main sequence
  initial begin
    doReset(1'b0);
    rdChk(16'hF024, 32'h00000005);
    chk("pins", {21'h0, pinRelease}, 32'h000007FA);
    rdChk(16'hF030, 32'h00000000);
    rt(24'h00E800, 4'h4, 11'h000, 1'b0);
    rt(24'h080000, 4'h4, 11'h000, 1'b0);
    rt(24'h100000, 4'h4, 11'h000, 1'b0);
    wr(16'hF024, 32'h00000121);
    wr(16'hF028, 32'h00000001);
    wr(16'hF024, 32'h00000000);
    rdChk(16'hF024, 32'h00000121);
    rdChk(16'hF02C, 32'h00000005);
    chk("pins", {21'h0, pinRelease}, 32'h000006DE);
    for (int i = 0; i < 9; i++) begin
      rt(tAddr[i], tRoute[i], tSel[i], 1'b0);
    end
    doReset(1'b1);
    wr(16'hF024, 32'h00000052);
    wr(16'hF028, 32'h00000001);
    rt(24'h00EE00, 4'h2, 11'h002, 1'b0);
    rt(24'h00ED00, 4'h2, 11'h010, 1'b0);
    rt(24'h00EC00, 4'h2, 11'h040, 1'b0);
    rt(24'h080000, 4'h2, 11'h000, 1'b1);
    wr(16'hF028, 32'h00000003);
    rt(24'h00EA00, 4'h2, 11'h200, 1'b0);
    wrap_up();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
